// ---- hdl/lfc_params.svh ----
// constants of the lcd frame clock and driver timing block
// Notes on behaviour
// - prescaler tap divides by 16 to 4096
// - divider adds factor of field plus one
// - frame lasts K times N times D ticks
// - reserved frame rate bits read zero
// - drive time code picks driver on-time
// - on-time never exceeds half prescaled period unless max drive is set
// - static duty or blanking uses half period
// - new drive time code acts at once
// - max drive keeps drivers always on
// - contrast code maps to 2.60 to 3.35
// - contrast code applied at next frame start
// - two-bit duty field sets K factor
// - source clock is system or oscillator
// - blanking grounds outputs after current frame
`ifndef LFC_PARAMS_SVH
`define LFC_PARAMS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define LFC_ADDR_CTRL_A 8'hE4
`define LFC_ADDR_CTRL_B 8'hE5
`define LFC_ADDR_FRR 8'hE6
`define LFC_ADDR_DCR 8'hE7
`define LFC_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LFC_A_BLANK 0
`define LFC_A_BLANK_ACT 1
`define LFC_B_SRC_SEL 7
`define LFC_B_DUTY_HI 5
`define LFC_B_DUTY_LO 4
`define LFC_F_PS_HI 6
`define LFC_F_PS_LO 4
`define LFC_F_CD_HI 2
`define LFC_F_CD_LO 0
`define LFC_D_DT_HI 7
`define LFC_D_DT_LO 5
`define LFC_D_MAX 4
`define LFC_D_CC_HI 3
`define LFC_D_CC_LO 0

// ----------------------------------------------------------------------
// prescaler taps as log2 of the ratio
// ----------------------------------------------------------------------
`define LFC_TAP_LOG0 4'h4
`define LFC_TAP_LOG1 4'h6
`define LFC_TAP_LOG2 4'h7
`define LFC_TAP_LOG3 4'h8
`define LFC_TAP_LOG4 4'h9
`define LFC_TAP_LOG5 4'hA
`define LFC_TAP_LOG6 4'hB
`define LFC_TAP_LOG7 4'hC

// frame factor minus one, and the drive time code that runs for the half period
`define LFC_K8_M1 3'h7
`define LFC_K6_M1 3'h5
`define LFC_DT_HALF 3'h7

// ----------------------------------------------------------------------
// drive times
// ----------------------------------------------------------------------
`define LFC_CLK_NS 10
`define LFC_DT0_US 300
`define LFC_DT1_US 70
`define LFC_DT2_US 150
`define LFC_DT3_US 450
`define LFC_DT4_US 575
`define LFC_DT5_US 850
`define LFC_DT6_US 1150
`define LFC_US_CYC(t) (((t) * 1000) / `LFC_CLK_NS)

// contrast voltage in units of 10 mV
`define LFC_V_BASE_CV 9'h104
`define LFC_V_STEP_CV 9'h005

`endif

// ---- hdl/lfc_pkg.sv ----
// types of the lcd frame clock and driver timing block
package lfc_pkg;

  typedef enum logic [1:0]
  {
    LFC_DUTY_STATIC = 2'h0,
    LFC_DUTY_HALF = 2'h1,
    LFC_DUTY_THIRD = 2'h2,
    LFC_DUTY_QUARTER = 2'h3
  } lfc_duty_t;

  typedef enum logic [1:0]
  {
    LFC_SHOW = 2'b01,
    LFC_BLANK = 2'b10
  } lfc_disp_t;

endpackage : lfc_pkg

// ---- hdl/lfc_modcnt.sv ----
// modulo counter that advances on a tick and wraps at a limit
`timescale 1ns/1ps

module lfc_modcnt #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] cnt,
  output logic wrap
);

  // >= so a limit lowered below the count still wraps at once
  assign wrap = tick && (cnt >= limit);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      cnt <= '0;
    else if (wrap)
      cnt <= '0;
    else if (tick)
      cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
  end

endmodule : lfc_modcnt

// ---- hdl/lfc_top.sv ----
// lcd frame clock generation, driver timing and contrast code
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "lfc_params.svh"

module lfc_top #(
  parameter int DT0_CYC = `LFC_US_CYC(`LFC_DT0_US),
  parameter int DT1_CYC = `LFC_US_CYC(`LFC_DT1_US),
  parameter int DT2_CYC = `LFC_US_CYC(`LFC_DT2_US),
  parameter int DT3_CYC = `LFC_US_CYC(`LFC_DT3_US),
  parameter int DT4_CYC = `LFC_US_CYC(`LFC_DT4_US),
  parameter int DT5_CYC = `LFC_US_CYC(`LFC_DT5_US),
  parameter int DT6_CYC = `LFC_US_CYC(`LFC_DT6_US)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic osc_clk_in,
  output logic prescaled_panel_clock,
  output logic frame_start,
  output logic driver_enable,
  output logic panel_ground,
  output logic [3:0] panel_max_voltage,
  output logic [8:0] panel_voltage_cv
);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic display_blank;
  logic source_clock_sel;
  lfc_pkg::lfc_duty_t duty_select;
  logic [2:0] prescale_tap_sel;
  logic [2:0] frame_clock_divide;
  logic [2:0] drive_time_sel;
  logic max_drive_enable;
  logic [3:0] contrast_level;
  lfc_pkg::lfc_disp_t disp_state;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      display_blank <= 1'b0;
      source_clock_sel <= 1'b0;
      duty_select <= lfc_pkg::LFC_DUTY_STATIC;
    end
    else if (wr_en && addr == `LFC_ADDR_CTRL_A)
      display_blank <= wdata[`LFC_A_BLANK];
    else if (wr_en && addr == `LFC_ADDR_CTRL_B)
    begin
      source_clock_sel <= wdata[`LFC_B_SRC_SEL];
      duty_select <= lfc_pkg::lfc_duty_t'(
        wdata[`LFC_B_DUTY_HI:`LFC_B_DUTY_LO]);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prescale_tap_sel <= 3'h0;
      frame_clock_divide <= 3'h0;
    end
    else if (wr_en && addr == `LFC_ADDR_FRR)
    begin
      prescale_tap_sel <= wdata[`LFC_F_PS_HI:`LFC_F_PS_LO];
      frame_clock_divide <= wdata[`LFC_F_CD_HI:`LFC_F_CD_LO];
    end
  end

  // drive time code used live by the driver logic below
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      drive_time_sel <= 3'h0;
      max_drive_enable <= 1'b0;
      contrast_level <= 4'h0;
    end
    else if (wr_en && addr == `LFC_ADDR_DCR)
    begin
      drive_time_sel <= wdata[`LFC_D_DT_HI:`LFC_D_DT_LO];
      max_drive_enable <= wdata[`LFC_D_MAX];
      contrast_level <= wdata[`LFC_D_CC_HI:`LFC_D_CC_LO];
    end
  end

  // --------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = `LFC_RST_BYTE;
    unique case (addr)
      `LFC_ADDR_CTRL_A:
      begin
        next_rdata[`LFC_A_BLANK] = display_blank;
        next_rdata[`LFC_A_BLANK_ACT] = (disp_state == lfc_pkg::LFC_BLANK);
      end
      `LFC_ADDR_CTRL_B:
      begin
        next_rdata[`LFC_B_SRC_SEL] = source_clock_sel;
        next_rdata[`LFC_B_DUTY_HI:`LFC_B_DUTY_LO] = duty_select;
      end
      `LFC_ADDR_FRR:
      begin
        // bits 7 and 3 stay zero
        next_rdata[`LFC_F_PS_HI:`LFC_F_PS_LO] = prescale_tap_sel;
        next_rdata[`LFC_F_CD_HI:`LFC_F_CD_LO] = frame_clock_divide;
      end
      `LFC_ADDR_DCR:
      begin
        next_rdata[`LFC_D_DT_HI:`LFC_D_DT_LO] = drive_time_sel;
        next_rdata[`LFC_D_MAX] = max_drive_enable;
        next_rdata[`LFC_D_CC_HI:`LFC_D_CC_LO] = contrast_level;
      end
      default: next_rdata = `LFC_RST_BYTE;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata <= `LFC_RST_BYTE;
    else if (rd_en)
      rdata <= next_rdata;
    else
      rdata <= `LFC_RST_BYTE;
  end

  // --------------------------------------------------------------------
  // source clock
  // --------------------------------------------------------------------
  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic osc_level;
  logic osc_rise;
  logic src_tick;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end
    else
    begin
      osc_s1 <= osc_clk_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // a level counts only once two later stages agree
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      osc_level <= 1'b0;
    else if (osc_s2 == osc_s3)
      osc_level <= osc_s3;
  end

  assign osc_rise = osc_s2 && osc_s3 && !osc_level;
  // oscillator must stay well below half of clk to be seen
  assign src_tick = source_clock_sel ? osc_rise : 1'b1;

  // --------------------------------------------------------------------
  // prescaler, divider and frame counter
  // --------------------------------------------------------------------
  logic [3:0] tap_log;
  logic [11:0] tap_limit;
  logic [11:0] pre_cnt;
  logic pre_wrap;
  logic [2:0] div_cnt;
  logic ps_tick;
  logic [2:0] k_limit;
  logic [2:0] frm_cnt;
  logic frame_wrap;

  always_comb
  begin
    unique case (prescale_tap_sel)
      3'h0: tap_log = `LFC_TAP_LOG0;
      3'h1: tap_log = `LFC_TAP_LOG1;
      3'h2: tap_log = `LFC_TAP_LOG2;
      3'h3: tap_log = `LFC_TAP_LOG3;
      3'h4: tap_log = `LFC_TAP_LOG4;
      3'h5: tap_log = `LFC_TAP_LOG5;
      3'h6: tap_log = `LFC_TAP_LOG6;
      3'h7: tap_log = `LFC_TAP_LOG7;
    endcase
  end

  assign tap_limit = 12'((13'h0001 << tap_log) - 13'h0001);
  // 1/3 duty has six phases per frame, others eight
  assign k_limit = (duty_select == lfc_pkg::LFC_DUTY_THIRD)
                   ? `LFC_K6_M1 : `LFC_K8_M1;

  lfc_modcnt #(.W(12)) u_prescale (
    .clk(clk),
    .reset(reset),
    .tick(src_tick),
    .limit(tap_limit),
    .cnt(pre_cnt),
    .wrap(pre_wrap)
  );

  // divide by field value plus one
  lfc_modcnt #(.W(3)) u_divide (
    .clk(clk),
    .reset(reset),
    .tick(pre_wrap),
    .limit(frame_clock_divide),
    .cnt(div_cnt),
    .wrap(ps_tick)
  );

  lfc_modcnt #(.W(3)) u_frame (
    .clk(clk),
    .reset(reset),
    .tick(ps_tick),
    .limit(k_limit),
    .cnt(frm_cnt),
    .wrap(frame_wrap)
  );

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      frame_start <= 1'b0;
    else
      frame_start <= frame_wrap;
  end

  // --------------------------------------------------------------------
  // half period tracking
  // --------------------------------------------------------------------
  logic [15:0] period_ticks;
  logic [14:0] half_ticks;
  logic [14:0] half_cnt;
  logic half_reached;

  assign period_ticks = 16'({4'h0, tap_limit} + 16'h0001)
                        * 16'({13'h0000, frame_clock_divide} + 16'h0001);
  assign half_ticks = period_ticks[15:1];
  // the tick in hand counts, else the high half runs one tick long
  assign half_reached = ({1'b0, half_cnt} + {15'h0000, src_tick})
                        >= {1'b0, half_ticks};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      half_cnt <= 15'h0000;
    else if (ps_tick)
      half_cnt <= 15'h0000;
    else if (src_tick && (half_cnt < half_ticks))
      half_cnt <= half_cnt + 15'h0001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prescaled_panel_clock <= 1'b0;
    else
      prescaled_panel_clock <= !half_reached || ps_tick;
  end

  // --------------------------------------------------------------------
  // blanking and contrast
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      disp_state <= lfc_pkg::LFC_SHOW;
    else if (frame_wrap)
      // the running frame always completes before blanking
      disp_state <= display_blank ? lfc_pkg::LFC_BLANK : lfc_pkg::LFC_SHOW;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      panel_ground <= 1'b0;
    else if (frame_wrap)
      panel_ground <= display_blank;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      panel_max_voltage <= 4'h0;
      panel_voltage_cv <= `LFC_V_BASE_CV;
    end
    else if (frame_wrap)
    begin
      panel_max_voltage <= contrast_level;
      panel_voltage_cv <= `LFC_V_BASE_CV
                          + 9'(`LFC_V_STEP_CV * {5'h00, contrast_level});
    end
  end

  // --------------------------------------------------------------------
  // driver on-time
  // --------------------------------------------------------------------
  logic [16:0] dt_limit;
  logic [16:0] drv_cnt;
  logic use_timed;
  logic drv_cut;

  always_comb
  begin
    unique case (drive_time_sel)
      3'h0: dt_limit = 17'(DT0_CYC);
      3'h1: dt_limit = 17'(DT1_CYC);
      3'h2: dt_limit = 17'(DT2_CYC);
      3'h3: dt_limit = 17'(DT3_CYC);
      3'h4: dt_limit = 17'(DT4_CYC);
      3'h5: dt_limit = 17'(DT5_CYC);
      3'h6: dt_limit = 17'(DT6_CYC);
      3'h7: dt_limit = 17'(DT6_CYC);
    endcase
  end

  // static duty, blanking and code 7 run for the half period only
  assign use_timed = (drive_time_sel != `LFC_DT_HALF)
                     && (duty_select != lfc_pkg::LFC_DUTY_STATIC)
                     && (disp_state != lfc_pkg::LFC_BLANK);
  // half period bounds every timed code too
  assign drv_cut = half_reached || (use_timed && drv_cnt >= dt_limit);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      drv_cnt <= 17'h00000;
    else if (ps_tick)
      drv_cnt <= 17'h00001;
    else if (driver_enable && !drv_cut)
      drv_cnt <= drv_cnt + 17'h00001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      driver_enable <= 1'b0;
    else if (max_drive_enable)
      driver_enable <= 1'b1;
    else if (ps_tick)
      driver_enable <= 1'b1;
    else if (drv_cut)
      driver_enable <= 1'b0;
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  AST_PS_TAP: assert property (
    @(posedge clk) disable iff (reset)
    pre_wrap |-> pre_cnt >= tap_limit && src_tick)
    else $error("prescaler wrapped off its tap");

  AST_DIV_FACTOR: assert property (
    @(posedge clk) disable iff (reset)
    ps_tick |-> pre_wrap && div_cnt >= frame_clock_divide)
    else $error("divider ticked at wrong count");

  AST_FRAME_K: assert property (
    @(posedge clk) disable iff (reset)
    frame_wrap |-> ps_tick && frm_cnt >= ((duty_select ==
      lfc_pkg::LFC_DUTY_THIRD) ? `LFC_K6_M1 : `LFC_K8_M1))
    else $error("frame length not K prescaled periods");

  AST_RSVD_ZERO: assert property (
    @(posedge clk) disable iff (reset)
    rd_en && addr == `LFC_ADDR_FRR |=> rdata[7] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved frame rate bit read as one");

  AST_TIMED_END: assert property (
    @(posedge clk) disable iff (reset)
    !max_drive_enable && !ps_tick && use_timed && driver_enable
      && drv_cnt >= dt_limit |=> !driver_enable)
    else $error("driver stayed on past drive time");

  AST_HALF_LIMIT: assert property (
    @(posedge clk) disable iff (reset)
    !max_drive_enable && !ps_tick && half_reached |=> !driver_enable)
    else $error("driver on past half prescaled period");

  AST_HALF_ONLY: assert property (
    @(posedge clk) disable iff (reset)
    !use_timed && !max_drive_enable && !half_reached && !ps_tick
      && driver_enable |=> driver_enable || ps_tick)
    else $error("untimed drive cut before half period");

  AST_MAX_DRIVE: assert property (
    @(posedge clk) disable iff (reset)
    max_drive_enable [*2] |-> driver_enable)
    else $error("max drive did not hold drivers on");

  AST_VOLT_MAP: assert property (
    @(posedge clk) disable iff (reset)
    panel_voltage_cv == `LFC_V_BASE_CV
      + 9'(`LFC_V_STEP_CV * {5'h00, panel_max_voltage}))
    else $error("voltage target does not match code");

  AST_CONTRAST_HOLD: assert property (
    @(posedge clk) disable iff (reset)
    !frame_wrap |=> $stable(panel_max_voltage))
    else $error("contrast changed away from frame start");

  AST_BLANK_GND: assert property (
    @(posedge clk) disable iff (reset)
    frame_wrap && display_blank |=> panel_ground && frame_start)
    else $error("blanking did not ground at frame end");

  AST_SOF_PULSE: assert property (
    @(posedge clk) disable iff (reset)
    frame_wrap |=> frame_start ##1 !frame_start)
    else $error("start of frame strobe not one cycle");

endmodule : lfc_top

// ---- verification/lfc_glass_model.sv ----
// glass model that measures the periods and drive pulses it receives
`timescale 1ns/1ps

module lfc_glass_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic prescaled_panel_clock,
  input wire logic frame_start,
  input wire logic driver_enable,
  output int ps_events,
  output int frame_events,
  output int ps_period,
  output int frame_period,
  output int on_time,
  output logic pulse_err
);
  logic ps_prev;
  int ps_cnt;
  int fr_cnt;
  int hi_cnt;

  // --------------------------------------------------------------------
  // prescaled clock period, counted between rising edges
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ps_prev <= 1'b0;
      ps_cnt <= 0;
      ps_events <= 0;
      ps_period <= 0;
    end
    else
    begin
      ps_prev <= prescaled_panel_clock;
      ps_cnt <= ps_cnt + 1;
      if (prescaled_panel_clock && !ps_prev)
      begin
        ps_period <= ps_cnt + 1;
        ps_cnt <= 0;
        ps_events <= ps_events + 1;
      end
    end
  end

  // --------------------------------------------------------------------
  // frame period; a strobe held two edges is flagged
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fr_cnt <= 0;
      frame_events <= 0;
      frame_period <= 0;
      pulse_err <= 1'b0;
    end
    else
    begin
      fr_cnt <= frame_start ? 0 : fr_cnt + 1;
      if (frame_start)
      begin
        frame_period <= fr_cnt + 1;
        frame_events <= frame_events + 1;
        pulse_err <= pulse_err | (fr_cnt == 0 && frame_events != 0);
      end
    end
  end

  // --------------------------------------------------------------------
  // length of the last completed driver-on pulse
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hi_cnt <= 0;
      on_time <= 0;
    end
    else if (driver_enable)
      hi_cnt <= hi_cnt + 1;
    else
    begin
      if (hi_cnt != 0)
        on_time <= hi_cnt;
      hi_cnt <= 0;
    end
  end
endmodule : lfc_glass_model

// ---- verification/lfc_top_tb.sv ----
// register-driven testbench of the frame clock and driver timing block
`timescale 1ns/1ps
`include "lfc_params.svh"

module lfc_top_tb;
  // short drive times keep the run small; half period at tap 256 is 128
  localparam int DT[7] = '{20, 30, 40, 50, 60, 70, 80};
  localparam int TAP_N[8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
  localparam logic [7:0] ADDRS[5] = '{`LFC_ADDR_CTRL_A, `LFC_ADDR_CTRL_B,
    `LFC_ADDR_FRR, `LFC_ADDR_DCR, 8'h10};
  localparam logic [7:0] FC_F[4] = '{8'h00, 8'h12, 8'h07, 8'h24};
  localparam logic [7:0] FC_B[4] = '{8'h00, 8'h20, 8'h30, 8'h10};
  localparam int FC_P[4] = '{128, 1152, 1024, 5120};

  logic clk, reset, wr_en, rd_en, osc_clk_in;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic ppc, fs, de, pg, pulse_err;
  logic [3:0] pmv;
  logic [8:0] pcv;
  int ps_events, frame_events, ps_period, frame_period, on_time;
  int fail_count, cmp_count, lows, prev;

  lfc_top #(
    .DT0_CYC(DT[0]), .DT1_CYC(DT[1]), .DT2_CYC(DT[2]), .DT3_CYC(DT[3]),
    .DT4_CYC(DT[4]), .DT5_CYC(DT[5]), .DT6_CYC(DT[6])
  ) i_lfc_top (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .osc_clk_in(osc_clk_in),
    .prescaled_panel_clock(ppc), .frame_start(fs), .driver_enable(de),
    .panel_ground(pg), .panel_max_voltage(pmv), .panel_voltage_cv(pcv)
  );

  lfc_glass_model i_lfc_glass_model (
    .clk(clk), .reset(reset), .prescaled_panel_clock(ppc),
    .frame_start(fs), .driver_enable(de), .ps_events(ps_events),
    .frame_events(frame_events), .ps_period(ps_period),
    .frame_period(frame_period), .on_time(on_time), .pulse_err(pulse_err)
  );

  // --------------------------------------------------------------------
  // clocks; the oscillator is offset so its edges never meet clk's
  // --------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    osc_clk_in = 1'b0;
    #3;
    forever #50 osc_clk_in = ~osc_clk_in;
  end

  // --------------------------------------------------------------------
  // bus tasks and comparison
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(what, {8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk

  // waits for n more prescaled edges (frm 0) or frame strobes (frm 1)
  task automatic wait_ev(input bit frm, input int n);
    int start;
    int k;
    start = frm ? frame_events : ps_events;
    k = 0;
    while (((frm ? frame_events : ps_events) - start) < n && k < 50000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 50000)
      check("event wait", 16'h0001, 16'h0000);
  endtask : wait_ev

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  initial
  begin
    #950000;
    fail_count++;
    print_verdict();
  end

  // --------------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1;
    check("voltage after reset", {7'h00, pcv}, 16'h0104);
    for (int i = 0; i < 5; i++)
      rd_chk(ADDRS[i], 8'h00, "reset value");
    wr(`LFC_ADDR_FRR, 8'hFF);
    rd_chk(`LFC_ADDR_FRR, 8'h77, "frame rate readback");
    for (int i = 0; i < 8; i++)
    begin
      wr(`LFC_ADDR_FRR, {1'b0, i[2:0], 4'h0});
      wait_ev(1'b0, 3);
      check("tap period", ps_period[15:0], TAP_N[i][15:0]);
    end
    for (int i = 0; i < 8; i++)
    begin
      wr(`LFC_ADDR_FRR, {5'h00, i[2:0]});
      wait_ev(1'b0, 3);
      check("divided period", ps_period[15:0], 16'(16 * (i + 1)));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`LFC_ADDR_CTRL_B, FC_B[i]);
      wr(`LFC_ADDR_FRR, FC_F[i]);
      wait_ev(1'b1, 3);
      check("frame period", frame_period[15:0], FC_P[i][15:0]);
    end
    // drive time codes, duty one half, prescaled period 256
    wr(`LFC_ADDR_CTRL_B, 8'h10);
    wr(`LFC_ADDR_FRR, 8'h30);
    for (int i = 0; i < 8; i++)
    begin
      wr(`LFC_ADDR_DCR, {i[2:0], 5'h00});
      wait_ev(1'b0, 3);
      check("on-time", on_time[15:0],
            (i == 7) ? 16'h0080 : DT[i][15:0]);
    end
    wr(`LFC_ADDR_FRR, 8'h00);
    wr(`LFC_ADDR_DCR, 8'hC0);
    wait_ev(1'b0, 3);
    check("clipped on-time", on_time[15:0], 16'd8);
    wr(`LFC_ADDR_FRR, 8'h30);
    wr(`LFC_ADDR_CTRL_B, 8'h00);
    wr(`LFC_ADDR_DCR, 8'h20);
    wait_ev(1'b0, 3);
    check("static on-time", on_time[15:0], 16'd128);
    wr(`LFC_ADDR_DCR, 8'h30);
    repeat (3) @(posedge clk);
    lows = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1;
      if (de !== 1'b1)
        lows++;
    end
    check("max drive gaps", lows[15:0], 16'h0000);
    rd_chk(`LFC_ADDR_DCR, 8'h30, "max drive readback");
    // blanking starts only at the frame end
    wr(`LFC_ADDR_DCR, 8'h20);
    wr(`LFC_ADDR_CTRL_B, 8'h10);
    wait_ev(1'b1, 1);
    wr(`LFC_ADDR_CTRL_A, 8'h01);
    rd_chk(`LFC_ADDR_CTRL_A, 8'h01, "blank pending");
    check("ground early", {15'h0000, pg}, 16'h0000);
    wait_ev(1'b1, 1);
    check("ground at frame", {15'h0000, pg}, 16'h0001);
    rd_chk(`LFC_ADDR_CTRL_A, 8'h03, "blank active");
    // drive code changed only while blanked, after a frame start
    wr(`LFC_ADDR_DCR, 8'h40);
    wait_ev(1'b0, 3);
    check("blank on-time", on_time[15:0], 16'd128);
    wr(`LFC_ADDR_CTRL_A, 8'h00);
    wait_ev(1'b1, 2);
    check("ground released", {15'h0000, pg}, 16'h0000);
    wait_ev(1'b0, 3);
    check("unblanked on-time", on_time[15:0], DT[2][15:0]);
    // oscillator source, 10 clk per tick, 16 ticks per period
    wr(`LFC_ADDR_FRR, 8'h00);
    wr(`LFC_ADDR_CTRL_B, 8'h90);
    wait_ev(1'b0, 3);
    check("osc period", ps_period[15:0], 16'd160);
    wr(`LFC_ADDR_CTRL_B, 8'h00);
    // contrast codes wait for the frame strobe
    prev = 0;
    for (int c = 0; c < 16; c++)
    begin
      wait_ev(1'b1, 1);
      wr(`LFC_ADDR_DCR, {4'h0, c[3:0]});
      #1;
      check("contrast held", {12'h000, pmv}, prev[15:0]);
      wait_ev(1'b1, 1);
      check("contrast code", {12'h000, pmv}, c[15:0]);
      check("voltage", {7'h00, pcv}, 16'(260 + 5 * c));
      prev = c;
    end
    check("strobe length", {15'h0000, pulse_err}, 16'h0000);
    print_verdict();
  end
endmodule : lfc_top_tb
